/* File: hw/ufec_top.sv */
// Control and status logic of one serial channel: enables, duplex and
// pacing modes, pause/resume symbols, address matching, fault flags.
// Assumes the receiver and transmitter sit on the same clock and that
// registers are reached by vendor register write and read requests.
// Function
// - Bit1 enables receiver, bit0 transmitter, reset off
// - Half duplex drops receive data while sending
// - Code 000 none, 001 hardware handshake
// - Code 010 received symbols gate transmitter
// - Code 011 receive only after address match
// - Code 100 both directions need address match
// - Resume symbol restarts transmitter, resets 0x11
// - Pause symbol stops transmitter, resets 0x13
// - Compare low eight bits, ninth bit zero
// - Resume unicast, pause multicast address
// - Fault flags accumulate, read clears them
// - Bit7 shows present break, read-only
// - Bit6 overrun when buffer full
// - Bit5 parity error, clears on read
// - Bit4 missing stop bit, clears on read
// - Bit3 break seen since read
// - Pin function 001 with code 001 gives request/clear handshake
`timescale 1ns/1ps
`include "ufec_regs.svh"
module ufec_top import ufec_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  // Register requests
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [9:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  output logic REG_RACK_O,
  // Receiver side
  input wire logic RX_VALID_I,
  input wire logic [8:0] RX_CHAR_I,
  input wire logic RX_FULL_I,
  input wire logic PARITY_ERR_I,
  input wire logic FRAME_ERR_I,
  input wire logic BRK_LINE_I,
  output logic RX_ENABLE_O,
  output logic RX_KEEP_O,
  // Transmitter side
  input wire logic TX_BUSY_I,
  output logic TX_ENABLE_O,
  output logic TX_PERMIT_O,
  // Handshake pins
  input wire logic [2:0] PIN_FUNC_I,
  input wire logic CTS_N_I,
  output logic RTS_N_O
);
  ufec_ctl_t s;
  ufec_ctl_t next_s;
  logic cts_n;
  logic seen;
  logic want;
  logic ovr_set;
  logic brk_rise;
  logic fault_rd;
  logic hw_pins;
  logic ovr_f;
  logic par_f;
  logic frm_f;
  logic brk_f;
  // ==========================================================
  // Pin synchroniser and fault flags
  ufec_sync #(.RST_VAL(1'b1)) u_cts (
    .clk_i(CLOCK_I),
    .rst_n_i(NRST_I),
    .pin_i(CTS_N_I),
    .level_o(cts_n)
  );
  ufec_sticky u_ovr (
    .clk_i(CLOCK_I),
    .rst_n_i(NRST_I),
    .set_i(ovr_set),
    .clr_i(fault_rd),
    .flag_o(ovr_f)
  );
  ufec_sticky u_par (
    .clk_i(CLOCK_I),
    .rst_n_i(NRST_I),
    .set_i(PARITY_ERR_I),
    .clr_i(fault_rd),
    .flag_o(par_f)
  );
  ufec_sticky u_frm (
    .clk_i(CLOCK_I),
    .rst_n_i(NRST_I),
    .set_i(FRAME_ERR_I),
    .clr_i(fault_rd),
    .flag_o(frm_f)
  );
  ufec_sticky u_brk (
    .clk_i(CLOCK_I),
    .rst_n_i(NRST_I),
    .set_i(brk_rise),
    .clr_i(fault_rd),
    .flag_o(brk_f)
  );
  // ==========================================================
  // Event terms
  // half duplex discard
  assign seen = RX_VALID_I & s.rx_on & ~(s.half_dup & TX_BUSY_I);
  assign fault_rd = REG_RD_I & (REG_ADDR_I == `UFEC_OFS_FAULT);
  assign brk_rise = BRK_LINE_I & ~s.brk_prev;
  assign ovr_set = want & RX_FULL_I;
  assign hw_pins = (s.mode == `UFEC_MODE_HW) & (PIN_FUNC_I == `UFEC_PINF_RTSCTS);
  // ==========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    next_s.rack = 1'b0;
    next_s.rx_keep = 1'b0;
    next_s.brk_prev = BRK_LINE_I;
    want = 1'b0;
    // Writes keep only implemented bits, so reserved bits read zero
    if (REG_WR_I)
    begin
      case (REG_ADDR_I)
        `UFEC_OFS_RUN:
        begin
          next_s.rx_on = REG_WDATA_I[`UFEC_BIT_RXEN];
          next_s.tx_on = REG_WDATA_I[`UFEC_BIT_TXEN];
        end
        `UFEC_OFS_PACING:
        begin
          next_s.half_dup = REG_WDATA_I[`UFEC_BIT_HDX];
          next_s.mode = REG_WDATA_I[2:0];
        end
        `UFEC_OFS_RESUME: next_s.resume = REG_WDATA_I[7:0];
        `UFEC_OFS_PAUSE: next_s.pause = REG_WDATA_I[7:0];
        default: next_s.rack = 1'b0;
      endcase
    end
    // Read answer, unmapped indexes read zero
    if (REG_RD_I)
    begin
      next_s.rack = 1'b1;
      case (REG_ADDR_I)
        `UFEC_OFS_RUN: next_s.rdata = {14'h0000, s.rx_on, s.tx_on};
        `UFEC_OFS_PACING: next_s.rdata = {12'h000, s.half_dup, s.mode};
        `UFEC_OFS_RESUME: next_s.rdata = {8'h00, s.resume};
        `UFEC_OFS_PAUSE: next_s.rdata = {8'h00, s.pause};
        `UFEC_OFS_FAULT: next_s.rdata = {8'h00, BRK_LINE_I, ovr_f, par_f, frm_f, brk_f, 3'h0};
        default: next_s.rdata = 16'h0000;
      endcase
    end
    // Received character handling
    if (seen)
    begin
      case (s.mode)
        `UFEC_MODE_SW:
        begin
          if (RX_CHAR_I == {1'b0, s.resume})
          begin
            next_s.tx_held = 1'b0;
          end
          else if (RX_CHAR_I == {1'b0, s.pause})
          begin
            next_s.tx_held = 1'b1;
          end
          else
          begin
            want = 1'b1;
          end
        end
        `UFEC_MODE_MD_RX, `UFEC_MODE_MD_RXTX:
        begin
          if (RX_CHAR_I[8])
          begin
            next_s.matched = (RX_CHAR_I[7:0] == s.resume) | (RX_CHAR_I[7:0] == s.pause);
          end
          else
          begin
            want = s.matched;
          end
        end
        // modes none and handshake pass data
        default: want = 1'b1;
      endcase
    end
    next_s.rx_keep = want & ~RX_FULL_I;
    // Pacing state is dropped once the channel is fully off
    if (!s.rx_on && !s.tx_on)
    begin
      next_s.tx_held = 1'b0;
      next_s.matched = 1'b0;
    end
    // Transmit gate follows the selected pacing mode
    case (s.mode)
      `UFEC_MODE_HW: next_s.tx_permit = s.tx_on & (~hw_pins | ~cts_n);
      `UFEC_MODE_SW: next_s.tx_permit = s.tx_on & ~s.tx_held;
      `UFEC_MODE_MD_RXTX: next_s.tx_permit = s.tx_on & s.matched;
      default: next_s.tx_permit = s.tx_on;
    endcase
    next_s.rts_n = ~(hw_pins & s.rx_on & ~RX_FULL_I);
  end
  // ==========================================================
  // State register
  always_ff @(posedge CLOCK_I)
  begin
    if (!NRST_I)
    begin
      s <= '0;
      s.resume <= `UFEC_RST_RESUME;
      s.pause <= `UFEC_RST_PAUSE;
      s.rts_n <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end
  // Outputs straight from the state register
  assign REG_RDATA_O = s.rdata;
  assign REG_RACK_O = s.rack;
  assign RX_ENABLE_O = s.rx_on;
  assign RX_KEEP_O = s.rx_keep;
  assign TX_ENABLE_O = s.tx_on;
  assign TX_PERMIT_O = s.tx_permit;
  assign RTS_N_O = s.rts_n;
  // ==========================================================
  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  sequence run_wr_s;
    REG_WR_I && REG_ADDR_I == `UFEC_OFS_RUN;
  endsequence
  sequence pause_rx_s;
    seen && s.mode == `UFEC_MODE_SW && RX_CHAR_I == {1'b0, s.pause};
  endsequence
  sequence resume_rx_s;
    seen && s.mode == `UFEC_MODE_SW && RX_CHAR_I == {1'b0, s.resume};
  endsequence
  run_enable_a: assert property (run_wr_s |=>
    TX_ENABLE_O == $past(REG_WDATA_I[0]) && RX_ENABLE_O == $past(REG_WDATA_I[1]))
    else $error("enable bits not taken");
  half_dup_a: assert property (RX_VALID_I && s.half_dup && TX_BUSY_I |=> !RX_KEEP_O)
    else $error("data kept while sending");
  plain_keep_a: assert property (seen && s.mode == `UFEC_MODE_NONE && !RX_FULL_I
    |=> RX_KEEP_O) else $error("plain data dropped");
  pause_stop_a: assert property (pause_rx_s ##1 !REG_WR_I |=> !TX_PERMIT_O)
    else $error("pause did not stop sending");
  resume_go_a: assert property (resume_rx_s |=> !s.tx_held)
    else $error("resume ignored");
  addr_match_a: assert property (seen && s.mode == `UFEC_MODE_MD_RX && RX_CHAR_I[8]
    && RX_CHAR_I[7:0] == s.resume |=> s.matched) else $error("unicast not matched");
  md_rx_gate_a: assert property (seen && s.mode == `UFEC_MODE_MD_RX && !RX_CHAR_I[8]
    && !s.matched |=> !RX_KEEP_O) else $error("data kept before match");
  md_tx_gate_a: assert property (s.mode == `UFEC_MODE_MD_RXTX && !s.matched
    |=> !TX_PERMIT_O) else $error("sent before match");
  rts_assert_a: assert property (hw_pins && s.rx_on && !RX_FULL_I |=> !RTS_N_O)
    else $error("request line not asserted");
  brk_live_a: assert property (fault_rd |=> REG_RACK_O
    && REG_RDATA_O[`UFEC_BIT_BRK_NOW] == $past(BRK_LINE_I)) else $error("break bit wrong");
  ovr_flag_a: assert property (ovr_set |=> ovr_f)
    else $error("overrun not flagged");
  // In the multidrop modes address characters steer matching and are never stored
  sequence addr_rx_s;
    seen && RX_CHAR_I[8] && (s.mode == `UFEC_MODE_MD_RX || s.mode == `UFEC_MODE_MD_RXTX);
  endsequence
  // In symbol pacing mode flow symbols are consumed and never reach the receive buffer
  sym_drop_a: assert property (pause_rx_s |=> !RX_KEEP_O)
    else $error("pause symbol kept");
  // In symbol pacing mode a held transmitter stays gated until a resume symbol arrives or both enables are cleared
  held_gate_a: assert property (s.mode == `UFEC_MODE_SW && s.tx_held
    |=> !TX_PERMIT_O) else $error("sent while paused");
  addr_drop_a: assert property (addr_rx_s |=> !RX_KEEP_O)
    else $error("address character kept");
  // Clear-to-send is judged after the synchroniser, never from the raw pin
  hw_gate_a: assert property (hw_pins && cts_n |=> !TX_PERMIT_O)
    else $error("sent without clear to send");
  rts_idle_a: assert property (!hw_pins |=> RTS_N_O)
    else $error("request line driven outside handshake");
  rd_answer_a: assert property (REG_RD_I |=> REG_RACK_O)
    else $error("read not answered");
  fault_bits_a: assert property (fault_rd |=>
    REG_RDATA_O[`UFEC_BIT_OVR] == $past(ovr_f)
    && REG_RDATA_O[`UFEC_BIT_PAR] == $past(par_f)
    && REG_RDATA_O[`UFEC_BIT_FRM] == $past(frm_f)
    && REG_RDATA_O[`UFEC_BIT_BRK] == $past(brk_f))
    else $error("fault flags misread");
endmodule

/* File: hw/ufec_regs.svh */
// Register offsets, field positions, reset values and mode codes of the
// serial channel control block. Assumes 10-bit register indexes.
`ifndef UFEC_REGS_SVH
`define UFEC_REGS_SVH
// ==========================================================
// Register indexes
`define UFEC_OFS_RUN 10'h000
`define UFEC_OFS_PACING 10'h006
`define UFEC_OFS_RESUME 10'h007
`define UFEC_OFS_PAUSE 10'h008
`define UFEC_OFS_FAULT 10'h009
// ==========================================================
// Field positions
`define UFEC_BIT_TXEN 0
`define UFEC_BIT_RXEN 1
`define UFEC_BIT_HDX 3
`define UFEC_BIT_BRK_NOW 7
`define UFEC_BIT_OVR 6
`define UFEC_BIT_PAR 5
`define UFEC_BIT_FRM 4
`define UFEC_BIT_BRK 3
// ==========================================================
// Reset values and codes
`define UFEC_RST_RESUME 8'h11
`define UFEC_RST_PAUSE 8'h13
`define UFEC_MODE_NONE 3'h0
`define UFEC_MODE_HW 3'h1
`define UFEC_MODE_SW 3'h2
`define UFEC_MODE_MD_RX 3'h3
`define UFEC_MODE_MD_RXTX 3'h4
`define UFEC_PINF_RTSCTS 3'h1
`endif

/* File: hw/ufec_pkg.sv */
// State types of the serial channel control block.
// Assumes nothing beyond a SystemVerilog compiler.
package ufec_pkg;
  // ==========================================================
  // Control state of the top module
  typedef struct packed {
    logic rx_on;
    logic tx_on;
    logic half_dup;
    logic [2:0] mode;
    logic [7:0] resume;
    logic [7:0] pause;
    logic tx_held;
    logic matched;
    logic brk_prev;
    logic [15:0] rdata;
    logic rack;
    logic rx_keep;
    logic tx_permit;
    logic rts_n;
  } ufec_ctl_t;
  // Three-stage pin synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } ufec_sync_t;
  // One sticky flag
  typedef struct packed {
    logic flag;
  } ufec_flag_t;
endpackage

/* File: hw/ufec_sync.sv */
// Three flip-flop synchroniser for a pin input.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ps
module ufec_sync import ufec_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pin and clean level
  input wire logic pin_i,
  output logic level_o
);
  ufec_sync_t s;
  ufec_sync_t next_s;
  // ==========================================================
  // The level only moves once stages two and three agree
  always_comb
  begin
    next_s = s;
    next_s.s1 = pin_i;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3)
    begin
      next_s.level = s.s3;
    end
  end
  // State register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s <= {4{RST_VAL}};
    end
    else
    begin
      s <= next_s;
    end
  end
  assign level_o = s.level;
endmodule

/* File: hw/ufec_sticky.sv */
// One read-to-clear fault flag; a set in the clearing cycle wins.
// Assumes set_i and clr_i are single-cycle pulses on clk_i.
`timescale 1ns/1ps
module ufec_sticky import ufec_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Event and clear
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  ufec_flag_t s;
  ufec_flag_t next_s;
  // ==========================================================
  // set beats clear
  always_comb
  begin
    next_s = s;
    next_s.flag = set_i | (s.flag & ~clr_i);
  end
  // State register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end
  assign flag_o = s.flag;
  // ==========================================================
  // Checks
  set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    set_i |=> flag_o) else $error("event lost on clear");
  read_clears_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clr_i && !set_i |=> !flag_o) else $error("flag not cleared by read");
endmodule

/* File: verification/ufec_remote.sv */
// Model of the remote serial device as seen through the receiver side.
// Assumes the core clock; every change is made just after a rising edge.
`timescale 1ns/1ps
module ufec_remote
(
  // Clock
  input wire logic clk_i,
  // Received character and line events
  output logic valid_o,
  output logic [8:0] char_o,
  output logic perr_o,
  output logic ferr_o,
  output logic brk_o,
  output logic cts_n_o
);
  // ==========================================================
  // Idle levels: line quiet, peer ready to accept
  initial
  begin
    valid_o = 1'b0;
    char_o = 9'h1a5;
    perr_o = 1'b0;
    ferr_o = 1'b0;
    brk_o = 1'b0;
    cts_n_o = 1'b0;
  end
  // One character with optional fault pulses; the old value is not left
  // on the data lines, so a late sampler cannot pass by luck
  // faults travel per character
  task automatic send(input logic [8:0] c, input logic pe, input logic fe);
    @(posedge clk_i);
    valid_o <= 1'b1;
    char_o <= c;
    perr_o <= pe;
    ferr_o <= fe;
    @(posedge clk_i);
    valid_o <= 1'b0;
    char_o <= ~c;
    perr_o <= 1'b0;
    ferr_o <= 1'b0;
  endtask
  // Break level and clear-to-send level
  task automatic line(input logic brk, input logic cts_n);
    @(posedge clk_i);
    brk_o <= brk;
    cts_n_o <= cts_n;
  endtask
endmodule

/* File: verification/uart_flow_error_control_bench.sv */
// Self-checking bench of the serial channel control block.
// Assumes the remote model on the receive side and a 40 MHz clock.
`timescale 1ns/1ps
`include "ufec_regs.svh"
module uart_flow_error_control_bench;
  logic clk, nrst, wr, rd, rack, rx_valid, rx_full, perr, ferr, brk;
  logic rx_en, rx_keep, tx_busy, tx_en, tx_permit, cts_n, rts_n;
  logic [9:0] addr;
  logic [15:0] wdata, rdata, lfsr;
  logic [8:0] rx_char;
  logic [2:0] pin_func;
  logic [7:0] res, pau, d;
  int bad_count = 0;
  int total_checks = 0;
  // ==========================================================
  // Clock, design and remote device
  always #12.5 clk = ~clk;
  ufec_top ufec_top_i (.CLOCK_I(clk), .NRST_I(nrst), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RACK_O(rack),
    .RX_VALID_I(rx_valid), .RX_CHAR_I(rx_char), .RX_FULL_I(rx_full),
    .PARITY_ERR_I(perr), .FRAME_ERR_I(ferr), .BRK_LINE_I(brk), .RX_ENABLE_O(rx_en),
    .RX_KEEP_O(rx_keep), .TX_BUSY_I(tx_busy), .TX_ENABLE_O(tx_en),
    .TX_PERMIT_O(tx_permit), .PIN_FUNC_I(pin_func), .CTS_N_I(cts_n), .RTS_N_O(rts_n));
  ufec_remote ufec_remote_i (.clk_i(clk), .valid_o(rx_valid), .char_o(rx_char),
    .perr_o(perr), .ferr_o(ferr), .brk_o(brk), .cts_n_o(cts_n));
  // ==========================================================
  // Helpers
  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Fresh data byte that is neither flow symbol
  task automatic new_data();
    lfsr = lfsr_next(lfsr);
    d = lfsr[7:0];
    while (d == res || d == pau)
      d++;
  endtask
  task automatic reg_wr(input logic [9:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Answer comes on the same edge that takes the request
  task automatic reg_rd(input logic [9:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check_val("read answer", 16'h0001, {15'h0, rack});
    check_val("read data", exp, rdata);
  endtask
  // Channel is switched off around every configuration write
  task automatic setup(input logic [3:0] m, input logic [1:0] en);
    reg_wr(`UFEC_OFS_RUN, 16'h0000);
    reg_wr(`UFEC_OFS_PACING, {12'h0, m});
    reg_wr(`UFEC_OFS_RUN, {14'h0, en});
  endtask
  task automatic rx(input logic [8:0] c, input logic k);
    ufec_remote_i.send(c, 1'b0, 1'b0);
    #1;
    check_val("keep", {15'h0, k}, {15'h0, rx_keep});
  endtask
  // Bounded wait; a permit that never settles ends the run
  task automatic wait_permit(input logic exp);
    int n;
    n = 0;
    #1; // Step off the edge so a value launched on it is seen settled
    while (tx_permit !== exp && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check_val("transmit permit", {15'h0, exp}, {15'h0, tx_permit});
    if (tx_permit !== exp)
      final_report();
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    {wr, rd, rx_full, tx_busy} = 4'h0;
    addr = 10'h000;
    wdata = 16'h0000;
    pin_func = 3'h0;
    lfsr = 16'h9441; // Seed 37953
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    reg_rd(`UFEC_OFS_RUN, 16'h0000);
    reg_rd(`UFEC_OFS_PACING, 16'h0000);
    reg_rd(`UFEC_OFS_RESUME, 16'h0011);
    reg_rd(`UFEC_OFS_PAUSE, 16'h0013);
    reg_rd(`UFEC_OFS_FAULT, 16'h0000);
    reg_rd(10'h005, 16'h0000);
    check_val("request pin", 16'h0001, {15'h0, rts_n});
    $display("test reset done");
    lfsr = lfsr_next(lfsr);
    res = lfsr[7:0];
    pau = lfsr[15:8] ^ 8'h5a;
    if (pau == res)
      pau = ~res;
    reg_wr(`UFEC_OFS_RESUME, {8'h0, res});
    reg_wr(`UFEC_OFS_PAUSE, {8'h0, pau});
    reg_rd(`UFEC_OFS_RESUME, {8'h0, res});
    reg_rd(`UFEC_OFS_PAUSE, {8'h0, pau});
    setup(4'h0, 2'b11);
    reg_rd(`UFEC_OFS_RUN, 16'h0003);
    check_val("enables", 16'h0003, {14'h0, rx_en, tx_en});
    rx({1'b0, pau}, 1'b1);
    repeat (6)
    begin
      new_data();
      rx({1'b0, d}, 1'b1);
    end
    wait_permit(1'b1);
    $display("test plain mode done");
    setup(4'h2, 2'b11);
    rx({1'b0, pau}, 1'b0);
    wait_permit(1'b0);
    new_data();
    rx({1'b0, d}, 1'b1);
    rx({1'b0, res}, 1'b0);
    wait_permit(1'b1);
    $display("test symbol pacing done");
    setup(4'h3, 2'b11);
    rx({1'b0, d}, 1'b0);
    rx({1'b1, res}, 1'b0);
    rx({1'b0, d}, 1'b1);
    wait_permit(1'b1);
    rx({1'b1, d}, 1'b0);
    rx({1'b0, d}, 1'b0);
    rx({1'b1, pau}, 1'b0);
    rx({1'b0, d}, 1'b1);
    setup(4'h4, 2'b11);
    wait_permit(1'b0);
    rx({1'b1, res}, 1'b0);
    wait_permit(1'b1);
    rx({1'b0, d}, 1'b1);
    $display("test multidrop done");
    setup(4'h8, 2'b11);
    @(posedge clk);
    tx_busy <= 1'b1;
    rx({1'b0, d}, 1'b0);
    tx_busy <= 1'b0;
    rx({1'b0, d}, 1'b1);
    setup(4'h1, 2'b11);
    pin_func <= `UFEC_PINF_RTSCTS;
    ufec_remote_i.line(1'b0, 1'b1);
    wait_permit(1'b0);
    ufec_remote_i.line(1'b0, 1'b0);
    wait_permit(1'b1);
    check_val("request pin", 16'h0000, {15'h0, rts_n});
    $display("test duplex and handshake done");
    setup(4'h0, 2'b11);
    ufec_remote_i.send({1'b0, d}, 1'b1, 1'b0);
    ufec_remote_i.send({1'b0, d}, 1'b0, 1'b1);
    rx_full <= 1'b1;
    rx({1'b0, d}, 1'b0);
    rx_full <= 1'b0;
    reg_rd(`UFEC_OFS_FAULT, 16'h0070);
    reg_rd(`UFEC_OFS_FAULT, 16'h0000);
    ufec_remote_i.line(1'b1, 1'b0);
    reg_rd(`UFEC_OFS_FAULT, 16'h0088);
    reg_rd(`UFEC_OFS_FAULT, 16'h0080);
    ufec_remote_i.line(1'b0, 1'b0);
    reg_rd(`UFEC_OFS_FAULT, 16'h0000);
    fork
      reg_rd(`UFEC_OFS_FAULT, 16'h0000);
      ufec_remote_i.send({1'b0, d}, 1'b1, 1'b0);
    join
    reg_rd(`UFEC_OFS_FAULT, 16'h0020);
    $display("test fault flags done");
    final_report();
  end
endmodule
